// *** hw/conv_clk_div.v ***
// Purpose: Conversion clock enable divider.
// Assumes: Divisor value 0 to 31; divide ratio is divisor plus one.
// Notes: Emits a one-cycle tick rather than a real clock to keep one domain.
`timescale 1ns/1ps
`default_nettype none
`include "conv_clk_div_inc.vh"

module conv_clk_div (
	// Clock and control
	input wire CLK_I,
	input wire RST_N_I,
	input wire CE_I,
	input wire RUN_I,
	// Divisor and tick
	input wire [4:0] DIV_I,
	output reg TICK_O
);
	reg [`DIV_CNT_W-1:0] cnt_r;

	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cnt_r <= 5'h00;
			TICK_O <= 1'b0;
		end else if (CE_I) begin
			if (!RUN_I) begin
				cnt_r <= 5'h00;
				TICK_O <= 1'b0;
			end else if (cnt_r >= DIV_I) begin
				cnt_r <= 5'h00;
				TICK_O <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 5'h01;
				TICK_O <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** hw/conv_clk_div_inc.vh ***
// Purpose: Width of the conversion clock divider count.
// Assumes: Included by the divider file only.
// Notes: Holds one definition and no logic.
`ifndef CONV_CLK_DIV_INC_VH
`define CONV_CLK_DIV_INC_VH
`define DIV_CNT_W 5
`endif

// *** hw/conv_ctrl.v ***
// Purpose: Conversion control of a successive-approximation converter.
// Assumes: 8-bit register port, synchronous inputs, analog core outside.
// Notes: Result word is sampled from the analog core on the twelfth conversion tick; no done strobe comes from the core.
//
// Operation
// - Conversion clock is system clock over divisor+1.
// - Start source field picks one of six triggers.
// - Software start by writing one to busy.
// - Busy stays high for the whole conversion.
// - Busy falling sets done flag, interrupt request.
// - Result is loaded on the same edge that sets the done flag.
// - Timers 2/3 overflow by low or high byte.
// - Default mode tracks except during conversion.
// - Low-power mode tracks three conversion clocks first.
// - External start low tracks, rising edge converts.
// - Tracking may stop in standby or sleep.
// - Low five bits select pin, sensor or supply.
// - Code 11110 routes temperature sensor to input.
// - Converter runs only while enabled, else shutdown.
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_consts.vh"

module conv_ctrl (
	// Clock, reset and enable
	input wire CLK_I,
	input wire RST_N_I,
	input wire CE_I,
	// Register port
	input wire [7:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	output reg [7:0] RDATA_O,
	// Trigger sources
	input wire TMR0_OVF_I,
	input wire TMR1_OVF_I,
	input wire TMR2_LO_OVF_I,
	input wire TMR2_HI_OVF_I,
	input wire TMR2_SPLIT_I,
	input wire TMR3_LO_OVF_I,
	input wire TMR3_HI_OVF_I,
	input wire TMR3_SPLIT_I,
	input wire EXT_START_I,
	input wire STANDBY_I,
	// Analog core
	input wire [11:0] RESULT_I,
	output reg TRACK_O,
	output reg CONVERT_O,
	output reg SAR_TICK_O,
	output reg POWER_O,
	output reg [4:0] POS_SEL_O,
	output reg TEMP_SEL_O,
	// Interrupt request
	output wire IRQ_O
);
	localparam ST_IDLE = 2'd0;
	localparam ST_TRACK = 2'd1;
	localparam ST_CONV = 2'd2;

	reg [7:0] ctrl_r;
	reg [7:0] cfg_r;
	reg [4:0] pos_r;
	reg [11:0] result_r;
	reg [1:0] state_r;
	reg [3:0] cnt_r;
	reg ext_d_r;
	wire tick;
	reg trig;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function sel;
		input [7:0] a;
		input [7:0] b;
		begin
			sel = WR_I && (a == b);
		end
	endfunction

	wire en = ctrl_r[`CTRL_EN_BIT];
	wire lowpow = ctrl_r[`CTRL_TM_BIT];
	wire [2:0] src = ctrl_r[`CTRL_SRC_LSB+2:`CTRL_SRC_LSB];
	wire ext_rise = EXT_START_I && !ext_d_r;
	wire soft_go = sel(ADDR_I, `CTRL_ADDR) && WDATA_I[`CTRL_BUSY_BIT];
	wire done_evt = (state_r == ST_CONV) && tick && (cnt_r == `CONV_CLKS - 4'h1);

	// ----------------------------------------------------------------
	// Conversion clock
	// ----------------------------------------------------------------
	// divisor plus one
	conv_clk_div u_div (
		.CLK_I(CLK_I),
		.RST_N_I(RST_N_I),
		.CE_I(CE_I),
		.RUN_I(en),
		.DIV_I(cfg_r[`CFG_DIV_LSB+4:`CFG_DIV_LSB]),
		.TICK_O(tick)
	);

	always @* begin
		case (src)
			`SRC_SOFT: trig = soft_go;
			`SRC_TMR0: trig = TMR0_OVF_I;
			`SRC_TMR2: trig = TMR2_SPLIT_I ? TMR2_LO_OVF_I : TMR2_HI_OVF_I;
			`SRC_TMR1: trig = TMR1_OVF_I;
			`SRC_EXT: trig = ext_rise;
			`SRC_TMR3: trig = TMR3_SPLIT_I ? TMR3_LO_OVF_I : TMR3_HI_OVF_I;
			default: trig = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			// The start pin idles high, so a low reset value would fake an edge.
			ext_d_r <= 1'b1;
			result_r <= 12'h000;
		end else if (CE_I) begin
			ext_d_r <= EXT_START_I;
			if (!en) begin
				state_r <= ST_IDLE;
				cnt_r <= 4'h0;
			end else begin
				case (state_r)
					ST_IDLE: begin
						cnt_r <= 4'h0;
						if (trig) begin
							state_r <= (lowpow && src != `SRC_EXT) ? ST_TRACK : ST_CONV;
						end
					end
					ST_TRACK: begin
						if (tick) begin
							cnt_r <= cnt_r + 4'h1;
							if (cnt_r == `TRACK_CLKS - 4'h1) begin
								cnt_r <= 4'h0;
								state_r <= ST_CONV;
							end
						end
					end
					ST_CONV: begin
						if (tick) begin
							cnt_r <= cnt_r + 4'h1;
						end
						if (done_evt) begin
							result_r <= RESULT_I;
							state_r <= ST_IDLE;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_r <= `CTRL_RESET;
			cfg_r <= `CFG_RESET;
			pos_r <= 5'h00;
		end else if (CE_I) begin
			if (sel(ADDR_I, `CTRL_ADDR)) begin
				ctrl_r[7:6] <= WDATA_I[7:6];
				ctrl_r[3:0] <= WDATA_I[3:0];
				// Done flag takes the written value here, so software may set or clear it.
				ctrl_r[`CTRL_DONE_BIT] <= WDATA_I[`CTRL_DONE_BIT];
			end
			if (sel(ADDR_I, `CFG_ADDR)) begin
				cfg_r <= WDATA_I;
			end
			if (sel(ADDR_I, `POS_SEL_ADDR)) begin
				pos_r <= WDATA_I[`POS_FIELD_W-1:0];
			end
			if (done_evt && en) begin
				ctrl_r[`CTRL_DONE_BIT] <= 1'b1;
			end
		end
	end

	assign IRQ_O = ctrl_r[`CTRL_DONE_BIT] && ctrl_r[3];

	// ----------------------------------------------------------------
	// Read data and analog outputs
	// ----------------------------------------------------------------
	always @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			RDATA_O <= 8'h00;
			TRACK_O <= 1'b0;
			CONVERT_O <= 1'b0;
			SAR_TICK_O <= 1'b0;
			POWER_O <= 1'b0;
			POS_SEL_O <= 5'h00;
			TEMP_SEL_O <= 1'b0;
		end else if (CE_I) begin
			case (ADDR_I)
				`CTRL_ADDR: RDATA_O <= {ctrl_r[7:5], state_r != ST_IDLE, ctrl_r[3:0]};
				`CFG_ADDR: RDATA_O <= cfg_r;
				`POS_SEL_ADDR: RDATA_O <= {3'h0, pos_r};
				`RES_LO_ADDR: RDATA_O <= result_r[7:0];
				`RES_HI_ADDR: RDATA_O <= {4'h0, result_r[11:8]};
				default: RDATA_O <= 8'h00;
			endcase
			POWER_O <= en;
			TRACK_O <= en && !STANDBY_I && (state_r != ST_CONV) &&
				(lowpow ? (state_r == ST_TRACK || (src == `SRC_EXT && !EXT_START_I)) : 1'b1);
			CONVERT_O <= en && (state_r == ST_CONV);
			SAR_TICK_O <= en && tick;
			POS_SEL_O <= pos_r;
			TEMP_SEL_O <= (pos_r == `POS_TEMP);
		end
	end
endmodule
`default_nettype wire

// *** hw/conv_ctrl_consts.vh ***
// Purpose: Constants for the converter conversion control block.
// Assumes: 8-bit special function register port, 40 MHz system clock.
// Notes: Only the positive input select register has a documented address.
`ifndef CONV_CTRL_CONSTS_VH
`define CONV_CTRL_CONSTS_VH

// ----------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------
`define POS_SEL_ADDR 8'hBB
`define CTRL_ADDR 8'hE8
`define CFG_ADDR 8'hBC
`define RES_LO_ADDR 8'hBD
`define RES_HI_ADDR 8'hBE
`define POS_SEL_RESET 8'h00
`define CTRL_RESET 8'h00
`define CFG_RESET 8'hF8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_EN_BIT 7
`define CTRL_TM_BIT 6
`define CTRL_DONE_BIT 5
`define CTRL_BUSY_BIT 4
`define CTRL_SRC_LSB 0
`define CFG_DIV_LSB 3
`define POS_FIELD_W 5

// ----------------------------------------------------------------
// Start source codes
// ----------------------------------------------------------------
`define SRC_SOFT 3'h0
`define SRC_TMR0 3'h1
`define SRC_TMR2 3'h2
`define SRC_TMR1 3'h3
`define SRC_EXT 3'h4
`define SRC_TMR3 3'h5

// ----------------------------------------------------------------
// Timing counts in conversion clocks
// ----------------------------------------------------------------
`define TRACK_CLKS 4'h3
`define CONV_CLKS 4'hC

// ----------------------------------------------------------------
// Positive input codes
// ----------------------------------------------------------------
`define POS_LAST_PIN 5'h14
`define POS_TEMP 5'h1E
`define POS_SUPPLY 5'h1F

`endif

// *** verif/conv_ctrl_properties.sv ***
// Purpose: Port assertions for the conversion control block.
// Assumes: The soft start check covers only writes with the tracking mode bit clear.
// Notes: Bound into every conv_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_chk (
	// Clock, reset and register port
	input wire CLK_I,
	input wire RST_N_I,
	input wire CE_I,
	input wire [7:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire WR_I,
	input wire STANDBY_I,
	// Analog core side
	input wire TRACK_O,
	input wire CONVERT_O,
	input wire SAR_TICK_O,
	input wire POWER_O,
	input wire [4:0] POS_SEL_O,
	input wire TEMP_SEL_O
);
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
default clocking @(posedge CLK_I); endclocking
default disable iff (!RST_N_I);
// A counter is cheaper than unrolling twelve ticks of varying spacing.
reg [4:0] tick_cnt_r;
always @(posedge CLK_I or negedge RST_N_I) begin
	if (!RST_N_I)
		tick_cnt_r <= 5'h00;
	else if (!CONVERT_O)
		tick_cnt_r <= 5'h00;
	else if (SAR_TICK_O)
		tick_cnt_r <= tick_cnt_r + 5'h01;
end
a_phase_overlap: assert property (!(TRACK_O && CONVERT_O))
	else $error("track and convert high together");
a_conv_length: assert property ($fell(CONVERT_O) && POWER_O |-> tick_cnt_r == 5'h0C)
	else $error("conversion tick count wrong");
a_off_idle: assert property (!POWER_O |-> !CONVERT_O && !SAR_TICK_O)
	else $error("activity while disabled");
a_temp_route: assert property (TEMP_SEL_O == (POS_SEL_O == 5'h1E))
	else $error("sensor routing mismatch");
a_pos_write: assert property (WR_I && CE_I && ADDR_I == 8'hBB ##1 CE_I
	|=> POS_SEL_O == $past(WDATA_I[4:0], 2))
	else $error("input select not taken");
a_standby_hold: assert property (STANDBY_I && CE_I |=> !TRACK_O)
	else $error("tracking during standby");
a_soft_start: assert property (WR_I && CE_I && ADDR_I == 8'hE8 && WDATA_I[7:4] == 4'h9
	&& WDATA_I[2:0] == 3'h0 && POWER_O && !CONVERT_O |-> ##[1:3] CONVERT_O)
	else $error("soft start ignored");
a_idle_track: assert property (POWER_O && !CONVERT_O && !STANDBY_I ##1 $fell(TRACK_O)
	|-> ($past(WR_I, 2) or ##[0:1] CONVERT_O))
	else $error("tracking dropped while idle");
c_conv_end: cover property ($fell(CONVERT_O));
c_standby: cover property (STANDBY_I && POWER_O);
c_temp: cover property (TEMP_SEL_O);
endmodule
bind conv_ctrl conv_ctrl_chk chk_u (.CLK_I, .RST_N_I, .CE_I, .ADDR_I, .WDATA_I, .WR_I,
	.STANDBY_I, .TRACK_O, .CONVERT_O, .SAR_TICK_O, .POWER_O, .POS_SEL_O, .TEMP_SEL_O);
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the conversion control block.
// Assumes: Register reads return data one cycle after the address.
// Notes: Results are predicted from a queue of driven sample words.
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic clk, rst_n, ce, wr, stby, split, fire, track, conv, tick, pwr, temp, irq, ext;
logic [7:0] addr, wdata, rdata, d;
logic [11:0] res;
logic [4:0] pos;
logic [5:0] ovf;
logic [2:0] src;
logic [31:0] seed, dv, w;
int err_total, num_checks, i;
int q[$];
conv_ctrl dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
	.WR_I(wr), .RDATA_O(rdata), .TMR0_OVF_I(ovf[0]), .TMR1_OVF_I(ovf[1]),
	.TMR2_LO_OVF_I(ovf[2]), .TMR2_HI_OVF_I(ovf[3]), .TMR2_SPLIT_I(split),
	.TMR3_LO_OVF_I(ovf[4]), .TMR3_HI_OVF_I(ovf[5]), .TMR3_SPLIT_I(split), .EXT_START_I(ext),
	.STANDBY_I(stby), .RESULT_I(res), .TRACK_O(track), .CONVERT_O(conv), .SAR_TICK_O(tick),
	.POWER_O(pwr), .POS_SEL_O(pos), .TEMP_SEL_O(temp), .IRQ_O(irq));
trig_src src_u (.CLK_I(clk), .FIRE_I(fire), .SRC_I(src), .SPLIT_I(split), .OVF_O(ovf), .EXT_O(ext));
// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function automatic logic [31:0] rnd();
	seed = seed ^ (seed << 13);
	seed = seed ^ (seed >> 17);
	seed = seed ^ (seed << 5);
	return seed;
endfunction
task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
	num_checks++;
	if (seen !== exp) begin
		err_total++;
		$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
	end
endtask
task automatic wr8(input logic [7:0] a, input logic [7:0] v);
	@(posedge clk);
	#2;
	addr = a;
	wdata = v;
	wr = 1'b1;
	@(posedge clk);
	#2;
	wr = 1'b0;
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] v);
	@(posedge clk);
	#2;
	addr = a;
	@(posedge clk);
	#1;
	v = rdata;
endtask
task automatic run(input logic [2:0] s, input logic tm);
	int n;
	int p;
	int nn;
	int off;
	p = dv + 1;
	nn = (tm && s != 3'h4) ? 15 : 12;
	off = (s == 3'h0) ? -2 : ((s == 3'h4) ? 4 : 1);
	w = rnd();
	res = w[11:0];
	q.push_back(res);
	wr8(8'hE8, {1'b1, tm, 2'b00, 1'b1, s});
	if (s == 3'h0) begin
		wr8(8'hE8, {1'b1, tm, 2'b01, 1'b1, s});
		wr8(8'hE8, {1'b1, tm, 2'b01, 1'b1, s});
	end else begin
		src = s;
		fire = 1'b1;
		@(posedge clk);
		#2;
		fire = 1'b0;
	end
	if (s == 3'h4) begin
		repeat (3) @(posedge clk);
		#2;
		chk(track, 1'b1);
	end
	n = 0;
	while (irq !== 1'b1 && n < 3000) begin
		@(posedge clk);
		#2;
		n++;
	end
	chk(n >= p * (nn - 1) + 1 + off && n <= p * nn + off, 1'b1);
	rd(8'hBD, d);
	chk(d, q[0][7:0]);
	rd(8'hBE, d);
	chk(d, {4'h0, q[0][11:8]});
	rd(8'hE8, d);
	chk(d[5:4], 2'b10);
	void'(q.pop_front());
	wr8(8'hE8, 8'h88);
	chk(irq, 1'b0);
	$display("conversion source %0d mode %0d done", s, tm);
endtask
task close_out;
	$display("checks %0d mismatches %0d", num_checks, err_total);
	if (err_total == 0 && num_checks > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
// ----------------------------------------------------------------
// Stimulus
// ----------------------------------------------------------------
initial begin
	clk = 1'b0;
	forever #12.5 clk = ~clk;
end
initial begin
	#1_500_000;
	err_total++;
	close_out();
end
initial begin
	{rst_n, wr, stby, split, fire, src, res, addr, wdata} = '0;
	ce = 1'b1;
	seed = 32'd44435;
	repeat (12) @(posedge clk);
	#2;
	rst_n = 1'b1;
	rd(8'hBB, d);
	chk(d, 8'h00);
	rd(8'hBC, d);
	chk(d, 8'hF8);
	for (i = 0; i < 6; i++) begin
		w = rnd();
		wr8(8'hBB, w[7:0]);
		rd(8'hBB, d);
		chk(d, {3'h0, w[4:0]});
	end
	wr8(8'hBB, 8'hFE);
	@(posedge clk);
	#2;
	chk(temp, 1'b1);
	chk(pos, 5'h1E);
	$display("input select test done");
	for (i = 0; i < 12; i++) begin
		dv = rnd() % 4;
		split = dv[0];
		wr8(8'hBC, {dv[4:0], 3'h0});
		run(i % 6, i / 6);
	end
	repeat (40) @(posedge clk);
	#2;
	chk({conv, irq}, 2'b00);
	wr8(8'hE8, 8'h18);
	repeat (40) @(posedge clk);
	#2;
	chk({pwr, conv, irq}, 3'h0);
	wr8(8'hE8, 8'h80);
	repeat (2) @(posedge clk);
	#2;
	chk(track, 1'b1);
	stby = 1'b1;
	repeat (2) @(posedge clk);
	#2;
	chk(track, 1'b0);
	stby = 1'b0;
	ce = 1'b0;
	wr8(8'hBB, 8'h01);
	ce = 1'b1;
	rd(8'hBB, d);
	chk(d, 8'h1E);
	$display("enable and standby test done");
	close_out();
end
endmodule
`default_nettype wire

// *** verif/trig_src.sv ***
// Purpose: Timer overflow and start pin model at the trigger inputs.
// Assumes: One trigger per request from the bench.
// Notes: The start pin idles high and dips low for six cycles.
`timescale 1ns/1ps
`default_nettype none
module trig_src (
	// Clock and request
	input wire logic CLK_I,
	input wire logic FIRE_I,
	input wire logic [2:0] SRC_I,
	input wire logic SPLIT_I,
	// Trigger lines
	output var logic [5:0] OVF_O,
	output var logic EXT_O
);
// ----------------------------------------------------------------
// Trigger generation
// ----------------------------------------------------------------
int cnt = 0;
initial OVF_O = 6'h00;
initial EXT_O = 1'b1;
always @(posedge CLK_I) begin
	OVF_O <= 6'h00;
	if (cnt > 1)
		cnt <= cnt - 1;
	if (cnt == 1) begin
		EXT_O <= 1'b1;
		cnt <= 0;
	end
	// one trigger per request, spaced by the bench
	if (FIRE_I) begin
		case (SRC_I)
			3'h1: OVF_O <= 6'h01;
			3'h3: OVF_O <= 6'h02;
			3'h2: OVF_O <= SPLIT_I ? 6'h04 : 6'h08;
			3'h5: OVF_O <= SPLIT_I ? 6'h10 : 6'h20;
			3'h4: begin
				EXT_O <= 1'b0;
				cnt <= 6;
			end
			default: ;
		endcase
	end
end
endmodule
`default_nettype wire
